// >>> include/ryp_pkg.sv
package ryp_pkg;

  //////////////////////////////////////////////////////////////////////////////
  // bus geometry
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int STRB_W = 4;

  //////////////////////////////////////////////////////////////////////////////
  // register byte offsets
  localparam logic [7:0] OFS_YEAR_NOW = 8'h0c;
  localparam logic [7:0] OFS_YEAR_CMP = 8'h10;
  localparam logic [7:0] OFS_YEAR_PRE = 8'h14;
  localparam logic [7:0] OFS_CTRL = 8'h18;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h1c;
  localparam logic [7:0] OFS_IRQ_RAW = 8'h20;
  localparam logic [7:0] OFS_IRQ_MSK_ST = 8'h24;
  localparam logic [7:0] OFS_IRQ_CLR = 8'h28;

  //////////////////////////////////////////////////////////////////////////////
  // field layout
  localparam int YEAR_W = 14;
  localparam int DIV_W = 15;
  localparam int TRIM_W = 10;
  localparam int DIV_LSB = 0;
  localparam int TRIM_LSB = 16;
  localparam int EN_BIT = 26;
  localparam int IRQ_CAL_BIT = 0;
  localparam int IRQ_TMR_BIT = 1;

  //////////////////////////////////////////////////////////////////////////////
  // reset values
  localparam logic [YEAR_W-1:0] YEAR_NOW_RST = 14'h2000;
  localparam logic [YEAR_W-1:0] YEAR_CMP_RST = 14'h2000;
  localparam logic [YEAR_W-1:0] YEAR_PRE_RST = 14'h0000;
  localparam logic [DIV_W-1:0] DIV_RST = 15'h7fff;
  localparam logic [TRIM_W-1:0] TRIM_RST = 10'h000;

  //////////////////////////////////////////////////////////////////////////////
  // timing: slow-clock cycles in one trim interval
  localparam logic [TRIM_W-1:0] TRIM_WINDOW = 10'h3ff;

  // axi responses
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef struct packed {
    logic [DIV_W-1:0] divider;
    logic [TRIM_W-1:0] trim;
  } ryp_scale_t;

  typedef struct packed {
    logic countdown;
    logic calendar;
  } ryp_irq_t;

  typedef enum {
    SEL_NONE,
    SEL_YEAR_NOW,
    SEL_YEAR_CMP,
    SEL_YEAR_PRE,
    SEL_CTRL,
    SEL_IRQ_MASK,
    SEL_IRQ_RAW,
    SEL_IRQ_MSK_ST,
    SEL_IRQ_CLR
  } ryp_sel_t;

endpackage : ryp_pkg

// >>> src/ryp_year_bcd.sv
`timescale 1ns/1ps
`default_nettype none

module ryp_year_bcd
  import ryp_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic load,
  input wire logic [YEAR_W-1:0] load_value,
  input wire logic step,
  output logic [YEAR_W-1:0] year_q
);

  logic [YEAR_W-1:0] year_d;
  logic [YEAR_W-1:0] inc;
  logic [3:0] carry;

  assign carry[0] = 1'b1;

  // three full bcd digits, carry rippling upward
  genvar g;
  generate
    for (g = 0; g < 3; g++)
    begin : g_digit
      logic [3:0] dig;
      assign dig = year_q[4*g +: 4];
      assign carry[g+1] = carry[g] & (dig == 4'h9);
      assign inc[4*g +: 4] = !carry[g] ? dig : ((dig == 4'h9) ? 4'h0 : dig + 4'h1);
    end
  endgenerate

  // thousands digit runs 0..3, so 3999 wraps to 0000
  assign inc[13:12] = !carry[3] ? year_q[13:12] : ((year_q[13:12] == 2'h3) ? 2'h0 : year_q[13:12] + 2'h1);

  always_comb
  begin
    year_d = year_q;
    if (load)
      year_d = load_value;
    else if (step)
      year_d = inc;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      year_q <= YEAR_NOW_RST;
    else
      year_q <= year_d;
  end

endmodule : ryp_year_bcd

`default_nettype wire

// >>> src/ryp_prescaler.sv
`timescale 1ns/1ps
`default_nettype none

module ryp_prescaler
  import ryp_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic slow_edge,
  input wire logic run,
  input wire ryp_scale_t cfg,
  output logic cal_tick_q,
  output logic tmr_tick_q
);

  logic [TRIM_W-1:0] win_q;
  logic [TRIM_W-1:0] del_q;
  logic [DIV_W-1:0] div_q;
  logic last;
  logic kept;
  logic wrap;

  assign last = (win_q == TRIM_WINDOW - 10'h001);
  // the first trim pulses of each interval are swallowed
  assign kept = slow_edge && (del_q >= cfg.trim);
  assign wrap = (div_q >= cfg.divider);

  //////////////////////////////////////////////////////////////////////////////
  // trim interval
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      win_q <= '0;
      del_q <= '0;
    end
    else if (slow_edge)
    begin
      if (last)
      begin
        win_q <= '0;
        del_q <= '0;
      end
      else
      begin
        win_q <= win_q + 10'h001;
        if (del_q < cfg.trim)
          del_q <= del_q + 10'h001;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // divide by divider plus one
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      div_q <= '0;
    else if (kept)
      div_q <= wrap ? '0 : div_q + 15'h0001;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cal_tick_q <= 1'b0;
      tmr_tick_q <= 1'b0;
    end
    else
    begin
      // divider zero: timer sees the raw slow clock, clockwatch stands still
      cal_tick_q <= run && kept && wrap && (cfg.divider != '0);
      tmr_tick_q <= (cfg.divider == '0) ? slow_edge : (kept && wrap);
    end
  end

endmodule : ryp_prescaler

`default_nettype wire

// >>> src/ryp_top.sv
// What this block does
// - the current year is a read-only 14-bit bcd value 0..3999 that resets to 2000.
// - the year compare field is a read/write 14-bit bcd value that resets to 2000 and feeds the alarm compare.
// - the year preset field is a read/write 14-bit bcd value reset to 0 that is loaded into the running year.
// - while calendar_enable is set, the second tick is the slow clock divided by prescale_divider plus one, 32768 by default.
// - with prescale_divider at zero the timer tick is the raw slow clock and the second tick stops.
// - trim_pulse_delete slow-clock pulses are removed in every 1023-cycle interval, none by default.
// - divider and trim writes are dropped while calendar_enable is set, and reads show the stored values.
// - once calendar_enable is set the control register ignores every write until reset.
// - mask bit 0 enables the calendar interrupt and resets to 0.
// - mask bit 1 enables the countdown interrupt and resets to 0.
// - raw status bits 0 and 1 show the unmasked calendar and countdown interrupts and reset to 0.
// - masked status bits are raw anded with mask and drive the two interrupt outputs.
// - writing 1 to clear bit 0 or bit 1 clears that raw interrupt, writing 0 does nothing.
//
// Implementation choice: the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none

module ryp_top
  import ryp_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [DATA_W-1:0] s_axi_wdata,
  input wire logic [STRB_W-1:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic slow_clock,
  input wire logic year_step,
  input wire logic year_load,
  input wire logic date_match,
  input wire logic countdown_event,
  output logic second_tick,
  output logic timer_tick,
  output logic calendar_enable,
  output logic [YEAR_W-1:0] year_now,
  output logic calendar_irq_out,
  output logic countdown_irq_out,
  output logic irq
);

  //////////////////////////////////////////////////////////////////////////////
  // declarations

  logic awready_q;
  logic wready_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic arready_q;
  logic rvalid_q;
  logic [1:0] rresp_q;
  logic [DATA_W-1:0] rdata_q;
  logic [ADDR_W-1:0] waddr_q;
  logic [DATA_W-1:0] wdata_q;
  logic [STRB_W-1:0] wstrb_q;

  logic [YEAR_W-1:0] year_cmp_q;
  logic [YEAR_W-1:0] year_pre_q;
  ryp_scale_t scale_q;
  logic en_q;
  ryp_irq_t mask_q;
  ryp_irq_t raw_q;
  ryp_irq_t raw_d;
  ryp_irq_t clr;
  ryp_irq_t set;
  logic calendar_irq_q;
  logic countdown_irq_q;
  logic irq_q;

  logic [2:0] sync_q;
  logic stable_q;
  logic slow_edge_q;
  logic start_q;

  logic do_wr;
  ryp_sel_t wsel;
  ryp_sel_t rsel;
  logic [DATA_W-1:0] wr_val;
  logic cal_tick;
  logic tmr_tick;

  //////////////////////////////////////////////////////////////////////////////
  // helpers

  function automatic ryp_sel_t decode(input logic [ADDR_W-1:0] a);
    ryp_sel_t s;
    s = SEL_NONE;
    case (a[ADDR_W-1:2])
      OFS_YEAR_NOW[ADDR_W-1:2]: s = SEL_YEAR_NOW;
      OFS_YEAR_CMP[ADDR_W-1:2]: s = SEL_YEAR_CMP;
      OFS_YEAR_PRE[ADDR_W-1:2]: s = SEL_YEAR_PRE;
      OFS_CTRL[ADDR_W-1:2]: s = SEL_CTRL;
      OFS_IRQ_MASK[ADDR_W-1:2]: s = SEL_IRQ_MASK;
      OFS_IRQ_RAW[ADDR_W-1:2]: s = SEL_IRQ_RAW;
      OFS_IRQ_MSK_ST[ADDR_W-1:2]: s = SEL_IRQ_MSK_ST;
      OFS_IRQ_CLR[ADDR_W-1:2]: s = SEL_IRQ_CLR;
      default: s = SEL_NONE;
    endcase
    return s;
  endfunction : decode

  // reserved positions are zero-filled here
  function automatic logic [DATA_W-1:0] read_reg(input ryp_sel_t s);
    logic [DATA_W-1:0] v;
    v = '0;
    case (s)
      SEL_YEAR_NOW: v = {18'h0_0000, year_now};
      SEL_YEAR_CMP: v = {18'h0_0000, year_cmp_q};
      SEL_YEAR_PRE: v = {18'h0_0000, year_pre_q};
      SEL_CTRL: v = {5'h00, en_q, scale_q.trim, 1'b0, scale_q.divider};
      SEL_IRQ_MASK: v = {30'h0000_0000, mask_q};
      SEL_IRQ_RAW: v = {30'h0000_0000, raw_q};
      SEL_IRQ_MSK_ST: v = {30'h0000_0000, raw_q & mask_q};
      default: v = '0;
    endcase
    return v;
  endfunction : read_reg

  function automatic logic [DATA_W-1:0] merge_lanes(
    input logic [DATA_W-1:0] old_v,
    input logic [DATA_W-1:0] new_v,
    input logic [STRB_W-1:0] strb
  );
    logic [DATA_W-1:0] r;
    r = old_v;
    for (int i = 0; i < STRB_W; i++)
    begin
      if (strb[i])
        r[8*i +: 8] = new_v[8*i +: 8];
    end
    return r;
  endfunction : merge_lanes

  //////////////////////////////////////////////////////////////////////////////
  // axi4-lite write channel: address and data held until both are in

  assign do_wr = !awready_q && !wready_q && !bvalid_q;
  assign wsel = decode(waddr_q);
  assign wr_val = merge_lanes(read_reg(wsel), wdata_q, wstrb_q);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      awready_q <= 1'b1;
      waddr_q <= '0;
    end
    else if (awready_q && s_axi_awvalid)
    begin
      awready_q <= 1'b0;
      waddr_q <= s_axi_awaddr;
    end
    else if (bvalid_q && s_axi_bready)
      awready_q <= 1'b1;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      wready_q <= 1'b1;
      wdata_q <= '0;
      wstrb_q <= '0;
    end
    else if (wready_q && s_axi_wvalid)
    begin
      wready_q <= 1'b0;
      wdata_q <= s_axi_wdata;
      wstrb_q <= s_axi_wstrb;
    end
    else if (bvalid_q && s_axi_bready)
      wready_q <= 1'b1;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
    end
    else if (do_wr)
    begin
      bvalid_q <= 1'b1;
      bresp_q <= (wsel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
    end
    else if (s_axi_bready)
      bvalid_q <= 1'b0;
  end

  //////////////////////////////////////////////////////////////////////////////
  // axi4-lite read channel

  assign rsel = decode(s_axi_araddr);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      arready_q <= 1'b1;
      rvalid_q <= 1'b0;
      rdata_q <= '0;
      rresp_q <= RESP_OKAY;
    end
    else if (arready_q && s_axi_arvalid)
    begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b1;
      rdata_q <= read_reg(rsel);
      rresp_q <= (rsel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
    end
    else if (rvalid_q && s_axi_rready)
    begin
      rvalid_q <= 1'b0;
      arready_q <= 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // year compare and preset

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      year_cmp_q <= YEAR_CMP_RST;
    else if (do_wr && wsel == SEL_YEAR_CMP)
      year_cmp_q <= wr_val[YEAR_W-1:0];
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      year_pre_q <= YEAR_PRE_RST;
    else if (do_wr && wsel == SEL_YEAR_PRE)
      year_pre_q <= wr_val[YEAR_W-1:0];
  end

  //////////////////////////////////////////////////////////////////////////////
  // control: locked for good once the clockwatch runs

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      scale_q.divider <= DIV_RST;
      scale_q.trim <= TRIM_RST;
      en_q <= 1'b0;
    end
    else if (do_wr && wsel == SEL_CTRL && !en_q)
    begin
      scale_q.divider <= wr_val[DIV_LSB +: DIV_W];
      scale_q.trim <= wr_val[TRIM_LSB +: TRIM_W];
      en_q <= wr_val[EN_BIT];
    end
  end

  // one-cycle pulse when the clockwatch is started, used to load the year
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      start_q <= 1'b0;
    else
      start_q <= do_wr && wsel == SEL_CTRL && !en_q && wr_val[EN_BIT];
  end

  //////////////////////////////////////////////////////////////////////////////
  // interrupt mask, raw status and clear

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      mask_q <= '0;
    else if (do_wr && wsel == SEL_IRQ_MASK)
    begin
      mask_q.calendar <= wr_val[IRQ_CAL_BIT];
      mask_q.countdown <= wr_val[IRQ_TMR_BIT];
    end
  end

  always_comb
  begin
    clr = '0;
    if (do_wr && wsel == SEL_IRQ_CLR)
    begin
      clr.calendar = wdata_q[IRQ_CAL_BIT] && wstrb_q[0];
      clr.countdown = wdata_q[IRQ_TMR_BIT] && wstrb_q[0];
    end
  end

  always_comb
  begin
    set.calendar = cal_tick && date_match && (year_now == year_cmp_q);
    set.countdown = countdown_event;
    // a new event in the clearing cycle keeps the flag up
    raw_d.calendar = set.calendar || (raw_q.calendar && !clr.calendar);
    raw_d.countdown = set.countdown || (raw_q.countdown && !clr.countdown);
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      raw_q <= '0;
    else
      raw_q <= raw_d;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      calendar_irq_q <= 1'b0;
      countdown_irq_q <= 1'b0;
      irq_q <= 1'b0;
    end
    else
    begin
      calendar_irq_q <= raw_d.calendar && mask_q.calendar;
      countdown_irq_q <= raw_d.countdown && mask_q.countdown;
      irq_q <= |(raw_d & mask_q);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // slow clock pin: three flops, edge counted once stages two and three agree

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      sync_q <= '0;
      stable_q <= 1'b0;
      slow_edge_q <= 1'b0;
    end
    else
    begin
      sync_q <= {sync_q[1:0], slow_clock};
      if (sync_q[1] == sync_q[2])
        stable_q <= sync_q[2];
      slow_edge_q <= (sync_q[1] == sync_q[2]) && sync_q[2] && !stable_q;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // prescaler and year counter

  ryp_prescaler u_prescaler (
    .aclk(aclk),
    .aresetn(aresetn),
    .slow_edge(slow_edge_q),
    .run(en_q),
    .cfg(scale_q),
    .cal_tick_q(cal_tick),
    .tmr_tick_q(tmr_tick)
  );

  ryp_year_bcd u_year (
    .aclk(aclk),
    .aresetn(aresetn),
    .load(start_q || (en_q && year_load)),
    .load_value(year_pre_q),
    .step(en_q && year_step),
    .year_q(year_now)
  );

  //////////////////////////////////////////////////////////////////////////////
  // outputs

  assign s_axi_awready = awready_q;
  assign s_axi_wready = wready_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rresp = rresp_q;
  assign s_axi_rdata = rdata_q;
  assign second_tick = cal_tick;
  assign timer_tick = tmr_tick;
  assign calendar_enable = en_q;
  assign calendar_irq_out = calendar_irq_q;
  assign countdown_irq_out = countdown_irq_q;
  assign irq = irq_q;

endmodule : ryp_top

`default_nettype wire

// >>> verification/ryp_top_asserts.sv
`timescale 1ns/1ps
`default_nettype none

module ryp_top_asserts
  import ryp_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [DATA_W-1:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic s_axi_bvalid,
  input wire logic year_step,
  input wire logic year_load,
  input wire logic countdown_event,
  input wire logic second_tick,
  input wire logic timer_tick,
  input wire logic calendar_enable,
  input wire logic [YEAR_W-1:0] year_now,
  input wire logic calendar_irq_out,
  input wire logic countdown_irq_out,
  input wire logic irq
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence rd_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  sequence year_inc;
    calendar_enable && year_step && !year_load;
  endsequence

  irq_or_a: assert property (irq == (calendar_irq_out | countdown_irq_out))
    else $error("irq differs from or of outputs");
  year_hold_a: assert property (!calendar_enable ##1 !calendar_enable |-> $stable(year_now))
    else $error("year moved while stopped");
  bcd_step_a: assert property (year_inc ##0 (year_now[3:0] != 4'h9) |=> year_now == $past(year_now) + 14'h1)
    else $error("year step wrong");
  bcd_wrap_a: assert property (year_inc ##0 (year_now == 14'h1999) |=> year_now == 14'h2000)
    else $error("year carry wrong");
  en_sticky_a: assert property (calendar_enable |=> calendar_enable)
    else $error("enable dropped");
  tick_gate_a: assert property (second_tick |-> calendar_enable && timer_tick)
    else $error("second tick without enable");
  tick_pulse_a: assert property (timer_tick |=> !timer_tick)
    else $error("timer tick too long");
  rd_lat_a: assert property (rd_take |=> s_axi_rvalid)
    else $error("read answer late");
  rd_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data not held");
  cd_rise_a: assert property ($rose(countdown_irq_out) |-> $past(countdown_event) || $past(s_axi_bvalid))
    else $error("countdown irq without cause");
endmodule : ryp_top_asserts

bind ryp_top ryp_top_asserts chk_u (.aclk, .aresetn, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
  .s_axi_rvalid, .s_axi_rready, .s_axi_bvalid, .year_step, .year_load, .countdown_event, .second_tick,
  .timer_tick, .calendar_enable, .year_now, .calendar_irq_out, .countdown_irq_out, .irq);

`default_nettype wire

// >>> verification/ryp_top_tb.sv
`timescale 1ns/1ps
`default_nettype none

module ryp_top_tb
  import ryp_pkg::*;
;
  logic aclk = 0, aresetn = 0;
  logic [ADDR_W-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [2:0] s_axi_awprot = '0, s_axi_arprot = '0;
  logic [DATA_W-1:0] s_axi_wdata = '0, s_axi_rdata;
  logic [STRB_W-1:0] s_axi_wstrb = '0;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  logic slow_clock = 0, year_step = 0, year_load = 0, date_match = 0, countdown_event = 0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, second_tick, timer_tick;
  logic calendar_enable, calendar_irq_out, countdown_irq_out, irq;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [YEAR_W-1:0] year_now;
  int n_mismatch = 0, check_count = 0, cyc = 0, tmr_cnt = 0, sec_cnt = 0;

  ryp_top dut_u (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .slow_clock, .year_step, .year_load, .date_match, .countdown_event,
    .second_tick, .timer_tick, .calendar_enable, .year_now, .calendar_irq_out, .countdown_irq_out, .irq);

  //////////////////////////////////////////////////////////////////////////////
  always #20 aclk = ~aclk;

  task automatic summarize();
    $display("counts mismatch=%0d checks=%0d", n_mismatch, check_count);
    if (n_mismatch == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : summarize

  always @(posedge aclk)
  begin
    cyc++;
    if (timer_tick === 1'b1)
      tmr_cnt++;
    if (second_tick === 1'b1)
      sec_cnt++;
    if (cyc == 40000)
    begin
      n_mismatch++;
      summarize();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] er);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    // bready rises one edge in, so it is never lowered and raised in one step
    do
    begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready)
        s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid !== 1'b1)
        s_axi_bready <= 1'b1;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    check(32'(s_axi_bresp), 32'(er));
  endtask : axw

  task automatic axr(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready)
        s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid !== 1'b1)
        s_axi_rready <= 1'b1;
    end while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    check(s_axi_rdata, exp);
    check(32'(s_axi_rresp), 32'(er));
  endtask : axr

  task automatic pls(input logic [2:0] k);
    {countdown_event, year_load, year_step} <= k;
    @(posedge aclk);
    {countdown_event, year_load, year_step} <= 3'b000;
    repeat (3) @(posedge aclk);
  endtask : pls

  // pin toggles slowly enough for the three-flop synchroniser
  task automatic sl(input int n);
    repeat (n)
    begin
      slow_clock <= 1'b1;
      repeat (4) @(posedge aclk);
      slow_clock <= 1'b0;
      repeat (4) @(posedge aclk);
    end
  endtask : sl

  task automatic rst();
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
  endtask : rst

  //////////////////////////////////////////////////////////////////////////////
  initial
  begin
    rst();
    axr(OFS_YEAR_NOW, 32'h0000_2000, RESP_OKAY);
    axr(OFS_YEAR_CMP, 32'h0000_2000, RESP_OKAY);
    axr(OFS_YEAR_PRE, 32'h0000_0000, RESP_OKAY);
    axr(OFS_CTRL, 32'h0000_7fff, RESP_OKAY);
    axr(OFS_IRQ_MASK, 32'h0000_0000, RESP_OKAY);
    axr(OFS_IRQ_RAW, 32'h0000_0000, RESP_OKAY);
    axr(OFS_IRQ_MSK_ST, 32'h0000_0000, RESP_OKAY);
    $display("test reset values done");
    axw(OFS_YEAR_CMP, 32'hffff_3999, 4'hf, RESP_OKAY);
    axr(OFS_YEAR_CMP, 32'h0000_3999, RESP_OKAY);
    axw(OFS_YEAR_CMP, 32'h0000_1234, 4'h1, RESP_OKAY);
    axr(OFS_YEAR_CMP, 32'h0000_3934, RESP_OKAY);
    axw(OFS_YEAR_PRE, 32'hffff_2468, 4'hf, RESP_OKAY);
    axr(OFS_YEAR_PRE, 32'h0000_2468, RESP_OKAY);
    axw(OFS_YEAR_NOW, 32'h0000_1111, 4'hf, RESP_OKAY);
    axr(OFS_YEAR_NOW, 32'h0000_2000, RESP_OKAY);
    axw(8'h2c, 32'h0000_0001, 4'hf, RESP_SLVERR);
    axr(8'h30, 32'h0000_0000, RESP_SLVERR);
    axw(OFS_IRQ_MASK, 32'hffff_ffff, 4'hf, RESP_OKAY);
    axr(OFS_IRQ_MASK, 32'h0000_0003, RESP_OKAY);
    axw(OFS_IRQ_MASK, 32'h0000_0000, 4'hf, RESP_OKAY);
    $display("test registers done");
    pls(3'b100);
    axr(OFS_IRQ_RAW, 32'h0000_0002, RESP_OKAY);
    axr(OFS_IRQ_MSK_ST, 32'h0000_0000, RESP_OKAY);
    check(32'(countdown_irq_out), 32'h0000_0000);
    axw(OFS_IRQ_MASK, 32'h0000_0002, 4'hf, RESP_OKAY);
    axr(OFS_IRQ_MSK_ST, 32'h0000_0002, RESP_OKAY);
    check(32'({irq, countdown_irq_out}), 32'h0000_0003);
    axw(OFS_IRQ_CLR, 32'h0000_0000, 4'hf, RESP_OKAY);
    axr(OFS_IRQ_RAW, 32'h0000_0002, RESP_OKAY);
    axw(OFS_IRQ_CLR, 32'h0000_0002, 4'hf, RESP_OKAY);
    axr(OFS_IRQ_RAW, 32'h0000_0000, RESP_OKAY);
    check(32'({irq, countdown_irq_out}), 32'h0000_0000);
    $display("test countdown irq done");
    axw(OFS_CTRL, 32'hf800_8003, 4'hf, RESP_OKAY);
    axr(OFS_CTRL, 32'h0000_0003, RESP_OKAY);
    tmr_cnt = 0;
    sl(40);
    check(32'(tmr_cnt inside {[9:11]}), 32'h0000_0001);
    axw(OFS_CTRL, 32'h0064_0001, 4'hf, RESP_OKAY);
    axr(OFS_CTRL, 32'h0064_0001, RESP_OKAY);
    tmr_cnt = 0;
    // trim starts at interval position 40: 100 dropped at once, 100 at the next start, 40 at the one after
    sl(2046);
    check(32'(tmr_cnt inside {[902:904]}), 32'h0000_0001);
    axw(OFS_CTRL, 32'h0000_0000, 4'hf, RESP_OKAY);
    tmr_cnt = 0;
    sec_cnt = 0;
    sl(16);
    check(32'(tmr_cnt inside {[15:17]}), 32'h0000_0001);
    check(32'(sec_cnt), 32'h0000_0000);
    $display("test prescaler done");
    rst();
    axw(OFS_YEAR_PRE, 32'h0000_1999, 4'hf, RESP_OKAY);
    axw(OFS_YEAR_CMP, 32'h0000_1999, 4'hf, RESP_OKAY);
    axw(OFS_CTRL, 32'h0400_0001, 4'hf, RESP_OKAY);
    repeat (3) @(posedge aclk);
    check(32'(calendar_enable), 32'h0000_0001);
    check(32'(year_now), 32'h0000_1999);
    axw(OFS_CTRL, 32'h0000_0005, 4'hf, RESP_OKAY);
    axr(OFS_CTRL, 32'h0400_0001, RESP_OKAY);
    pls(3'b001);
    check(32'(year_now), 32'h0000_2000);
    pls(3'b001);
    axr(OFS_YEAR_NOW, 32'h0000_2001, RESP_OKAY);
    pls(3'b010);
    check(32'(year_now), 32'h0000_1999);
    date_match <= 1'b1;
    axw(OFS_IRQ_MASK, 32'h0000_0001, 4'hf, RESP_OKAY);
    sec_cnt = 0;
    sl(4);
    check(32'(sec_cnt inside {[1:3]}), 32'h0000_0001);
    axr(OFS_IRQ_RAW, 32'h0000_0001, RESP_OKAY);
    axr(OFS_IRQ_MSK_ST, 32'h0000_0001, RESP_OKAY);
    check(32'({irq, calendar_irq_out}), 32'h0000_0003);
    date_match <= 1'b0;
    axw(OFS_IRQ_CLR, 32'h0000_0001, 4'hf, RESP_OKAY);
    axr(OFS_IRQ_RAW, 32'h0000_0000, RESP_OKAY);
    check(32'(irq), 32'h0000_0000);
    $display("test calendar done");
    summarize();
  end
endmodule : ryp_top_tb

`default_nettype wire
